// [common/lld_pkg.sv]
// package for the first-loop lock detect and status pin block
package lld_pkg;
    // register indices (printed offsets are not all multiples of four)
    localparam logic [9:0] IDX_LOCK_HI = 10'h15C;
    localparam logic [9:0] IDX_LOCK_LO = 10'h15D;
    localparam logic [9:0] IDX_EXIT_OFS = 10'h15E;
    localparam logic [9:0] IDX_PIN_CFG = 10'h15F;
    localparam logic [9:0] IDX_CTRL = 10'h170;
    localparam logic [9:0] IDX_STAT = 10'h171;
    localparam logic [9:0] IDX_IRQ_ST = 10'h172;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h173;
    localparam logic [11:0] ADDR_LOCK_HI = {IDX_LOCK_HI, 2'b00};
    localparam logic [11:0] ADDR_LOCK_LO = {IDX_LOCK_LO, 2'b00};
    localparam logic [11:0] ADDR_EXIT_OFS = {IDX_EXIT_OFS, 2'b00};
    localparam logic [11:0] ADDR_PIN_CFG = {IDX_PIN_CFG, 2'b00};
    localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
    localparam logic [11:0] ADDR_IRQ_ST = {IDX_IRQ_ST, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    // reset values
    localparam logic [5:0] RST_LOCK_HI = 6'h20;
    localparam logic [7:0] RST_LOCK_LO = 8'h00;
    localparam logic [4:0] RST_EXIT_OFS = 5'h1E;
    localparam logic [4:0] RST_PIN_SEL = 5'h01;
    localparam logic [2:0] RST_PIN_TYPE = 3'h6;
    localparam logic [1:0] RST_WINDOW = 2'h3;
    // field positions
    localparam int POS_PIN_SEL = 3;
    localparam int POS_WINDOW = 8;
    localparam int POS_HOLD_EXIT = 0;
    // phase window widths in ns, per code
    localparam int WIN_NS_0 = 4;
    localparam int WIN_NS_1 = 9;
    localparam int WIN_NS_2 = 19;
    localparam int WIN_NS_3 = 43;
    // interrupt bits
    localparam int IRQ_LOCK_GAINED = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_EXIT = 2;
    localparam int IRQ_W = 3;
    // pin io types
    typedef enum logic [2:0] {
        LLD_IO_IN = 3'h0,
        LLD_IO_IN_PU = 3'h1,
        LLD_IO_IN_PD = 3'h2,
        LLD_IO_PP = 3'h3,
        LLD_IO_PP_INV = 3'h4,
        LLD_IO_RSVD = 3'h5,
        LLD_IO_OD = 3'h6,
        LLD_IO_RSVD7 = 3'h7
    } lld_io_t;
    // realign sequence states
    typedef enum logic [1:0] {
        LLD_RUN = 2'b00,
        LLD_HOLD = 2'b01,
        LLD_ALIGN = 2'b11
    } lld_seq_t;
endpackage : lld_pkg

// [common/lld_cfg_if.sv]
// interface carrying lock-detect configuration and result between modules
`timescale 1ns/1ps
interface lld_cfg_if;
    logic [13:0] lock_cycle_target;
    logic [1:0] phase_window_select;
    logic [5:0] phase_error;
    logic compare_valid;
    logic digital_lock_flag;
    logic lock_gained;
    logic lock_lost;
    modport ctrl (
        output lock_cycle_target,
        output phase_window_select,
        output phase_error,
        output compare_valid,
        input digital_lock_flag,
        input lock_gained,
        input lock_lost
    );
    modport det (
        input lock_cycle_target,
        input phase_window_select,
        input phase_error,
        input compare_valid,
        output digital_lock_flag,
        output lock_gained,
        output lock_lost
    );
endinterface : lld_cfg_if

// [rtl/lld_sync.sv]
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module lld_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // change taken once second and third stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= RST_VAL;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule : lld_sync

// [rtl/lld_lock_det.sv]
// consecutive in-window counter that declares digital lock
`timescale 1ns/1ps
module lld_lock_det #(
    parameter int CNT_W = 14
) (
    input wire logic hclk,
    input wire logic hresetn,
    lld_cfg_if.det cfg
);
    logic [CNT_W-1:0] run_q;
    logic [5:0] limit;
    logic in_win;
    always_comb begin
        unique case (cfg.phase_window_select)
            2'd0: limit = 6'(lld_pkg::WIN_NS_0);
            2'd1: limit = 6'(lld_pkg::WIN_NS_1);
            2'd2: limit = 6'(lld_pkg::WIN_NS_2);
            2'd3: limit = 6'(lld_pkg::WIN_NS_3);
        endcase
    end
    assign in_win = cfg.phase_error < limit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= '0;
            cfg.digital_lock_flag <= 1'b0;
            cfg.lock_gained <= 1'b0;
            cfg.lock_lost <= 1'b0;
        end else begin
            cfg.lock_gained <= 1'b0;
            cfg.lock_lost <= 1'b0;
            if (cfg.compare_valid) begin
                if (!in_win) begin
                    run_q <= '0;
                    cfg.digital_lock_flag <= 1'b0;
                    cfg.lock_lost <= cfg.digital_lock_flag;
                end else if (cfg.lock_cycle_target != '0) begin
                    if (run_q < cfg.lock_cycle_target) begin
                        run_q <= run_q + 1'b1;
                    end
                    // zero target never locks; a lowered target locks on the next hit
                    if (run_q >= cfg.lock_cycle_target - 1'b1 && !cfg.digital_lock_flag) begin
                        cfg.digital_lock_flag <= 1'b1;
                        cfg.lock_gained <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : lld_lock_det

// [rtl/lld_top.sv]
// first-loop lock detect, holdover realign and status pin with ahb-lite registers
// Functional notes
// - lock count is 14 bits: six high bits at 0x15C, eight low at 0x15D
// - lock declared after programmed run of in-window cycles; zero count is reserved
// - lock count high part resets to 32, low part to zero
// - holdover exit resets first-loop reference and feedback divider counters
// - five-bit signed exit offset sets divider restart skew; resets to 30
// - selector 0..7: low, lock1, lock2, both, holdover, dac locked, low (6), readback (7)
// - second-loop reference selections valid only when pin two selector not 2 or 3
// - io types 0..2 make the pin a loss-of-signal input with pull options
// - type 3 push-pull, 4 inverted, 6 open drain; default 6
// - counter grows on comparisons under selected window of 4, 9, 19 or 43 ns
`timescale 1ns/1ps
module lld_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic compare_valid,
    input wire logic [5:0] phase_error,
    input wire logic holdover_active,
    input wire logic second_loop_lock,
    input wire logic dac_locked,
    input wire logic dac_rail,
    input wire logic dac_low,
    input wire logic dac_high,
    input wire logic readback_data,
    input wire logic first_loop_feedback_divider,
    input wire logic second_loop_feedback_divider,
    input wire logic first_loop_reference_divider,
    input wire logic second_loop_reference_divider,
    input wire logic [4:0] status_pin_two_select,
    input wire logic status_pin_one_in,
    output logic status_pin_one_out,
    output logic status_pin_one_oe,
    output logic status_pin_one_pull_up,
    output logic status_pin_one_pull_down,
    output logic clock_input_two_loss_of_signal,
    output logic first_loop_divider_reset,
    output logic [4:0] holdover_exit_offset,
    output logic digital_lock_flag,
    output logic irq
);
    lld_cfg_if cfg_if ();
    logic [5:0] lock_hi_q;
    logic [7:0] lock_lo_q;
    logic [4:0] exit_ofs_q;
    logic [4:0] pin_sel_q;
    logic [2:0] pin_type_q;
    logic [1:0] window_q;
    logic [lld_pkg::IRQ_W-1:0] irq_st_q;
    logic [lld_pkg::IRQ_W-1:0] irq_mask_q;
    logic [lld_pkg::IRQ_W-1:0] irq_set;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] rd_data;
    logic [11:0] a_addr;
    logic a_valid;
    logic hold_q;
    logic exit_evt;
    logic los_sync;
    logic half_n1_q;
    logic half_n2_q;
    logic half_r1_q;
    logic half_r2_q;
    logic mux_val;
    logic los_d;
    lld_pkg::lld_seq_t seq_q;

    // ahb-lite slave, zero wait state
    assign a_valid = hsel && hready && htrans[1];
    assign a_addr = haddr[11:0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= a_valid && hwrite;
            wr_addr_q <= a_addr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (a_addr)
            lld_pkg::ADDR_LOCK_HI: rd_data = {26'h0, lock_hi_q};
            lld_pkg::ADDR_LOCK_LO: rd_data = {24'h0, lock_lo_q};
            lld_pkg::ADDR_EXIT_OFS: rd_data = {27'h0, exit_ofs_q};
            lld_pkg::ADDR_PIN_CFG: rd_data = {24'h0, pin_sel_q, pin_type_q};
            lld_pkg::ADDR_CTRL: rd_data = {22'h0, window_q, 8'h00};
            lld_pkg::ADDR_STAT: rd_data = {29'h0, los_sync, hold_q, cfg_if.digital_lock_flag};
            lld_pkg::ADDR_IRQ_ST: rd_data = {29'h0, irq_st_q};
            lld_pkg::ADDR_IRQ_MASK: rd_data = {29'h0, irq_mask_q};
            default: rd_data = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (a_valid && !hwrite) begin
            hrdata <= rd_data;
        end
    end

    // configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_hi_q <= lld_pkg::RST_LOCK_HI;
            lock_lo_q <= lld_pkg::RST_LOCK_LO;
            exit_ofs_q <= lld_pkg::RST_EXIT_OFS;
            pin_sel_q <= lld_pkg::RST_PIN_SEL;
            pin_type_q <= lld_pkg::RST_PIN_TYPE;
            window_q <= lld_pkg::RST_WINDOW;
            irq_mask_q <= '0;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                lld_pkg::ADDR_LOCK_HI: lock_hi_q <= hwdata[5:0];
                lld_pkg::ADDR_LOCK_LO: lock_lo_q <= hwdata[7:0];
                lld_pkg::ADDR_EXIT_OFS: exit_ofs_q <= hwdata[4:0];
                lld_pkg::ADDR_PIN_CFG: begin
                    pin_sel_q <= hwdata[lld_pkg::POS_PIN_SEL +: 5];
                    pin_type_q <= hwdata[2:0];
                end
                lld_pkg::ADDR_CTRL: window_q <= hwdata[lld_pkg::POS_WINDOW +: 2];
                lld_pkg::ADDR_IRQ_MASK: irq_mask_q <= hwdata[lld_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // lock detector
    assign cfg_if.lock_cycle_target = {lock_hi_q, lock_lo_q};
    assign cfg_if.phase_window_select = window_q;
    assign cfg_if.phase_error = phase_error;
    assign cfg_if.compare_valid = compare_valid;
    lld_lock_det #(
        .CNT_W(14)
    ) u_det (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg_if.det)
    );

    // holdover exit: reset both dividers, restart with signed skew
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b0;
            seq_q <= lld_pkg::LLD_RUN;
            first_loop_divider_reset <= 1'b0;
        end else begin
            hold_q <= holdover_active;
            first_loop_divider_reset <= 1'b0;
            unique case (seq_q)
                lld_pkg::LLD_RUN: if (holdover_active) seq_q <= lld_pkg::LLD_HOLD;
                lld_pkg::LLD_HOLD: if (!holdover_active) seq_q <= lld_pkg::LLD_ALIGN;
                lld_pkg::LLD_ALIGN: begin
                    first_loop_divider_reset <= 1'b1;
                    seq_q <= lld_pkg::LLD_RUN;
                end
                default: seq_q <= lld_pkg::LLD_RUN;
            endcase
        end
    end
    assign exit_evt = (seq_q == lld_pkg::LLD_ALIGN);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            holdover_exit_offset <= lld_pkg::RST_EXIT_OFS;
        end else begin
            holdover_exit_offset <= exit_ofs_q;
        end
    end

    // interrupts; a set in the clear cycle wins
    always_comb begin
        irq_set = '0;
        irq_set[lld_pkg::IRQ_LOCK_GAINED] = cfg_if.lock_gained;
        irq_set[lld_pkg::IRQ_LOCK_LOST] = cfg_if.lock_lost;
        irq_set[lld_pkg::IRQ_EXIT] = exit_evt;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= '0;
        end else if (wr_pend_q && wr_addr_q == lld_pkg::ADDR_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~hwdata[lld_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_st_q <= irq_st_q | irq_set;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_st_q | irq_set) & irq_mask_q);
        end
    end

    // halved divider outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_n1_q <= 1'b0;
            half_n2_q <= 1'b0;
            half_r1_q <= 1'b0;
            half_r2_q <= 1'b0;
        end else begin
            half_n1_q <= half_n1_q ^ first_loop_feedback_divider;
            half_n2_q <= half_n2_q ^ second_loop_feedback_divider;
            half_r1_q <= half_r1_q ^ first_loop_reference_divider;
            half_r2_q <= half_r2_q ^ second_loop_reference_divider;
        end
    end

    // status pin selector
    always_comb begin
        unique case (pin_sel_q)
            5'd0: mux_val = 1'b0;
            5'd1: mux_val = cfg_if.digital_lock_flag;
            5'd2: mux_val = second_loop_lock;
            5'd3: mux_val = cfg_if.digital_lock_flag & second_loop_lock;
            5'd4: mux_val = holdover_active;
            5'd5: mux_val = dac_locked;
            5'd7: mux_val = readback_data;
            5'd8: mux_val = dac_rail;
            5'd9: mux_val = dac_low;
            5'd10: mux_val = dac_high;
            5'd11: mux_val = first_loop_feedback_divider;
            5'd12: mux_val = half_n1_q;
            5'd13: mux_val = second_loop_feedback_divider;
            5'd14: mux_val = half_n2_q;
            5'd15: mux_val = first_loop_reference_divider;
            5'd16: mux_val = half_r1_q;
            // pin two showing second-loop lock makes these unreliable
            5'd17: mux_val = (status_pin_two_select == 5'd2 || status_pin_two_select == 5'd3)
                             ? 1'b0 : second_loop_reference_divider;
            5'd18: mux_val = (status_pin_two_select == 5'd2 || status_pin_two_select == 5'd3)
                             ? 1'b0 : half_r2_q;
            default: mux_val = 1'b0;
        endcase
    end

    // pin driver by io type
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_pin_one_out <= 1'b0;
            status_pin_one_oe <= 1'b0;
            status_pin_one_pull_up <= 1'b0;
            status_pin_one_pull_down <= 1'b0;
        end else begin
            status_pin_one_out <= 1'b0;
            status_pin_one_oe <= 1'b0;
            status_pin_one_pull_up <= (pin_type_q == lld_pkg::LLD_IO_IN_PU);
            status_pin_one_pull_down <= (pin_type_q == lld_pkg::LLD_IO_IN_PD);
            unique case (pin_type_q)
                lld_pkg::LLD_IO_PP: begin
                    status_pin_one_out <= mux_val;
                    status_pin_one_oe <= 1'b1;
                end
                lld_pkg::LLD_IO_PP_INV: begin
                    status_pin_one_out <= ~mux_val;
                    status_pin_one_oe <= 1'b1;
                end
                lld_pkg::LLD_IO_OD: begin
                    status_pin_one_out <= 1'b0;
                    status_pin_one_oe <= ~mux_val;
                end
                default: ;
            endcase
        end
    end

    // external loss-of-signal input
    lld_sync #(
        .RST_VAL(1'b0)
    ) u_los_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(status_pin_one_in),
        .level_q(los_sync)
    );
    assign los_d = (pin_type_q == lld_pkg::LLD_IO_IN || pin_type_q == lld_pkg::LLD_IO_IN_PU
                    || pin_type_q == lld_pkg::LLD_IO_IN_PD) && los_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_input_two_loss_of_signal <= 1'b0;
            digital_lock_flag <= 1'b0;
        end else begin
            clock_input_two_loss_of_signal <= los_d;
            digital_lock_flag <= cfg_if.digital_lock_flag;
        end
    end
endmodule : lld_top

// [test/lld_assertions.sv]
// port-level assertions for the lock detect block
`timescale 1ns/1ps
module lld_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic compare_valid,
    input wire logic [5:0] phase_error,
    input wire logic holdover_active,
    input wire logic status_pin_one_in,
    input wire logic status_pin_one_oe,
    input wire logic status_pin_one_pull_up,
    input wire logic status_pin_one_pull_down,
    input wire logic clock_input_two_loss_of_signal,
    input wire logic first_loop_divider_reset,
    input wire logic digital_lock_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay_ready: assert property (hreadyout && !hresp) else $error("bus wait");
    a_lock_needs_hit: assert property ($rose(digital_lock_flag) |->
        $past(compare_valid, 2) && $past(phase_error, 2) < 6'd43) else $error("lock");
    a_miss_drops_lock: assert property (compare_valid && phase_error >= 6'd43 |->
        ##2 !digital_lock_flag) else $error("miss kept lock");
    a_exit_pulse_due: assert property ($fell(holdover_active) |->
        ##[1:3] first_loop_divider_reset) else $error("no divider reset");
    a_pulse_one_cycle: assert property (first_loop_divider_reset |=>
        !first_loop_divider_reset) else $error("long pulse");
    a_pulse_has_cause: assert property (first_loop_divider_reset |->
        !$past(holdover_active)) else $error("stray pulse");
    a_input_not_driven: assert property (clock_input_two_loss_of_signal ||
        status_pin_one_pull_up || status_pin_one_pull_down |-> !status_pin_one_oe)
        else $error("input driven");
    a_single_pull: assert property (!(status_pin_one_pull_up && status_pin_one_pull_down))
        else $error("two pulls");
    a_pin_level_seen: assert property ($rose(clock_input_two_loss_of_signal) |->
        $past(status_pin_one_in, 3)) else $error("loss rose early");
endmodule : lld_assertions

bind lld_top lld_assertions i_chk (.hclk, .hresetn, .hreadyout, .hresp, .compare_valid,
    .phase_error, .holdover_active, .status_pin_one_in, .status_pin_one_oe,
    .status_pin_one_pull_up, .status_pin_one_pull_down, .clock_input_two_loss_of_signal,
    .first_loop_divider_reset, .digital_lock_flag);

// [test/lld_pin_model.sv]
// board logic on the first status pin
`timescale 1ns/1ps
module lld_pin_model (
    input wire logic hclk,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pull_up,
    input wire logic pull_down,
    input wire logic drive_en,
    input wire logic drive_val,
    output logic pin
);
    logic float_q = 1'b0;
    // undriven wire shows a changing pattern
    always @(posedge hclk) float_q <= ~float_q;
    always_comb begin
        if (pin_oe) pin = pin_out;
        else if (drive_en) pin = drive_val;
        else if (pull_up) pin = 1'b1;
        else if (pull_down) pin = 1'b0;
        else pin = float_q;
    end
endmodule : lld_pin_model

// [test/lld_top_tb.sv]
// self-checking bench for the lock detect and status pin block
`timescale 1ns/1ps
module lld_top_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic cv = 1'b0;
    logic [5:0] perr = 6'h00;
    logic hold = 1'b0;
    logic [9:0] src = 10'h000;
    logic [4:0] pin2 = 5'h00;
    logic drv_en = 1'b0, drv_val = 1'b0;
    logic [31:0] hrdata;
    logic [4:0] ofs;
    logic hreadyout, hresp, p_out, p_oe, p_pu, p_pd, p_in, loss, div_rst, flag, irq;
    logic lock_m = 1'b0;
    logic [2:0] irq_m = 3'h0;
    logic [3:0] half_m = 4'h0;
    int tgt = 8192;
    int cnt = 0, win = 43;
    int n_fail = 0, n_checks = 0;
    int seed = 69;
    int wins [4] = '{4, 9, 19, 43};

    always #25 hclk = ~hclk;
    always @(posedge hclk) if (hresetn) half_m <= half_m ^ src[9:6];

    lld_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .compare_valid(cv),
        .phase_error(perr), .holdover_active(hold), .second_loop_lock(src[0]),
        .dac_locked(src[1]), .dac_rail(src[2]), .dac_low(src[3]), .dac_high(src[4]),
        .readback_data(src[5]), .first_loop_feedback_divider(src[6]),
        .second_loop_feedback_divider(src[7]), .first_loop_reference_divider(src[8]),
        .second_loop_reference_divider(src[9]), .status_pin_two_select(pin2),
        .status_pin_one_in(p_in), .status_pin_one_out(p_out), .status_pin_one_oe(p_oe),
        .status_pin_one_pull_up(p_pu), .status_pin_one_pull_down(p_pd),
        .clock_input_two_loss_of_signal(loss), .first_loop_divider_reset(div_rst),
        .holdover_exit_offset(ofs), .digital_lock_flag(flag), .irq(irq)
    );

    lld_pin_model i_pin (.hclk(hclk), .pin_out(p_out), .pin_oe(p_oe), .pull_up(p_pu),
        .pull_down(p_pd), .drive_en(drv_en), .drive_val(drv_val), .pin(p_in));

    task automatic give_verdict;
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : chk_bit

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk_reg(q, e);
    endtask : rchk

    // one comparison, then the model steps and the flag is compared
    task automatic cmp(input logic [5:0] e);
        logic lock_n;
        @(posedge hclk);
        cv <= 1'b1;
        perr <= e;
        @(posedge hclk);
        cv <= 1'b0;
        cnt = (e < win) ? cnt + 1 : 0;
        lock_n = tgt != 0 && cnt >= tgt;
        irq_m[0] = irq_m[0] | (lock_n & ~lock_m);
        irq_m[1] = irq_m[1] | (lock_m & ~lock_n);
        lock_m = lock_n;
        @(posedge hclk);
        #1;
        chk_bit(flag, lock_m);
    endtask : cmp

    task automatic set_tgt(input int t);
        cmp(6'h3F);
        wr(lld_pkg::ADDR_LOCK_HI, 32'(t >> 8));
        wr(lld_pkg::ADDR_LOCK_LO, 32'(t & 255));
        tgt = t;
    endtask : set_tgt

    function automatic logic mux_exp(input int s);
        case (s)
            1: return lock_m;
            2: return src[0];
            3: return lock_m & src[0];
            4: return hold;
            5: return src[1];
            7: return src[5];
            8, 9, 10: return src[s-6];
            11, 13, 15: return src[(s - 11) / 2 + 6];
            12, 14, 16: return half_m[(s - 12) / 2];
            17: return (pin2 == 5'h02 || pin2 == 5'h03) ? 1'b0 : src[9];
            18: return (pin2 == 5'h02 || pin2 == 5'h03) ? 1'b0 : half_m[3];
            default: return 1'b0;
        endcase
    endfunction : mux_exp

    initial begin
        #(50 * 20000);
        n_fail++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        logic m, seen;
        logic [1:0] e2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(lld_pkg::ADDR_LOCK_HI, 32'h0000_0020);
        rchk(lld_pkg::ADDR_LOCK_LO, 32'h0000_0000);
        rchk(lld_pkg::ADDR_EXIT_OFS, 32'h0000_001E);
        rchk(lld_pkg::ADDR_PIN_CFG, 32'h0000_000E);
        chk_reg({27'h000_0000, ofs}, 32'h0000_001E);
        r = $random(seed);
        wr(lld_pkg::ADDR_EXIT_OFS, r);
        wr(12'h600, r);
        rchk(12'h600, 32'h0000_0000);
        rchk(lld_pkg::ADDR_EXIT_OFS, r & 32'h0000_001F);
        chk_reg({27'h000_0000, ofs}, r & 32'h0000_001F);
        wr(lld_pkg::ADDR_LOCK_HI, r);
        rchk(lld_pkg::ADDR_LOCK_HI, r & 32'h0000_003F);
        set_tgt(0);
        repeat (4) cmp(6'h00);
        for (int w = 0; w < 4; w++) begin
            wr(lld_pkg::ADDR_CTRL, 32'(w) << 8);
            win = wins[w];
            set_tgt(w + 1);
            repeat (w + 1) cmp(6'(win - 1));
            cmp(6'(win));
            repeat (12) cmp(6'($unsigned($random(seed)) % (win + 3)));
        end
        set_tgt(256);
        repeat (256) cmp(6'h00);
        rchk(lld_pkg::ADDR_IRQ_ST, {29'h0000_0000, irq_m});
        wr(lld_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge hclk);
        #1;
        chk_bit(irq, |irq_m);
        wr(lld_pkg::ADDR_IRQ_ST, 32'h0000_0007);
        irq_m = 3'h0;
        wr(lld_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
        rchk(lld_pkg::ADDR_IRQ_ST, 32'h0000_0000);
        @(posedge hclk);
        hold <= 1'b1;
        repeat (4) @(posedge hclk);
        hold <= 1'b0;
        seen = 1'b0;
        repeat (6) begin
            @(posedge hclk);
            #1;
            if (div_rst === 1'b1) seen = 1'b1;
        end
        chk_bit(seen, 1'b1);
        rchk(lld_pkg::ADDR_IRQ_ST, 32'h0000_0004);
        chk_bit(irq, 1'b0);
        wr(lld_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge hclk);
        #1;
        chk_bit(irq, 1'b1);
        wr(lld_pkg::ADDR_IRQ_ST, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        #1;
        chk_bit(irq, 1'b0);
        for (int ty = 3; ty < 7; ty++) begin
            if (ty == 5) continue;
            for (int s = 0; s < 19; s++) begin
                @(posedge hclk);
                src <= 10'($random(seed));
                pin2 <= 5'((s + ty) % 4);
                wr(lld_pkg::ADDR_PIN_CFG, 32'(s * 8 + ty));
                repeat (2) @(posedge hclk);
                #1;
                m = mux_exp(s);
                @(posedge hclk);
                #1;
                e2 = (ty == 3) ? {1'b1, m} : (ty == 4) ? {1'b1, ~m} : {~m, 1'b0};
                chk_reg({30'h0, p_oe, p_out}, {30'h0, e2});
            end
        end
        drv_en <= 1'b1;
        for (int ty = 0; ty < 3; ty++) begin
            for (int v = 0; v < 2; v++) begin
                @(posedge hclk);
                drv_val <= v[0];
                wr(lld_pkg::ADDR_PIN_CFG, 32'(8 + ty));
                repeat (8) @(posedge hclk);
                #1;
                chk_bit(loss, v[0]);
                chk_bit(p_oe, 1'b0);
            end
            chk_reg({30'h0, p_pu, p_pd}, {30'h0, ty == 1, ty == 2});
            if (ty != 0) begin
                drv_en <= 1'b0;
                repeat (8) @(posedge hclk);
                #1;
                chk_bit(loss, ty == 1);
                drv_en <= 1'b1;
            end
        end
        give_verdict();
    end
endmodule : lld_top_tb
